// ### rtl/fcs_pkg.sv
// Purpose: shared constants and types for the memory integrity scanner
// Assumes: 32-bit APB, register index times four gives the byte address
// Notes:   offsets below are register indices
package fcs_pkg;
    // register indices (byte address = index * 4)
    localparam logic [1:0] FCS_IDX_CTRL = 2'h0;  // scan_control
    localparam logic [1:0] FCS_IDX_MR   = 2'h1;  // scan_mode_region
    localparam logic [1:0] FCS_IDX_STAT = 2'h2;  // scan_result_flags
    // scan_control bit positions
    localparam int FCS_B_EN   = 0;               // enable
    localparam int FCS_B_ARM  = 1;               // fault_irq_arm
    localparam int FCS_B_SRST = 7;               // soft reset strobe
    // scan_mode_region field positions
    localparam int FCS_MODE_LO = 4;              // mode bits 5:4
    localparam int FCS_REG_LO  = 0;              // region_select bits 1:0
    // scan_result_flags bit positions
    localparam int FCS_B_BUSY = 0;               // busy flag
    localparam int FCS_B_OK   = 1;               // pass flag
    // values after reset
    localparam logic [7:0] FCS_CTRL_RST = 8'h00;
    localparam logic [7:0] FCS_MR_RST   = 8'h00;
    localparam logic [7:0] FCS_STAT_RST = 8'h02;
    // mode encodings
    localparam logic [1:0] FCS_MODE_PRIO = 2'h0; // stall cpu, single
    localparam logic [1:0] FCS_MODE_BG   = 2'h2; // background, single
    localparam logic [1:0] FCS_MODE_CONT = 2'h3; // background, repeating
    // region encodings
    localparam logic [1:0] FCS_REG_FULL = 2'h0;  // whole memory
    localparam logic [1:0] FCS_REG_LDPG = 2'h1;  // loader_and_program
    localparam logic [1:0] FCS_REG_LDR  = 2'h2;  // loader only
    // cycle counts
    localparam logic [1:0] FCS_START_CYC = 2'h3; // enable to first fetch
    localparam logic [1:0] FCS_FETCH_CYC = 2'h3; // priority fetch spacing
    // checksum engine
    localparam logic [15:0] FCS_CRC_INIT = 16'hffff;
    localparam logic [15:0] FCS_CRC_POLY = 16'h1021;
    // fault interrupt vector offset
    localparam logic [7:0] FCS_NMI_VEC = 8'h00;
    // scanner configuration
    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] region;
    } fcs_cfg_t;
    // scanner status flags
    typedef struct packed {
        logic ok;
        logic busy;
    } fcs_stat_t;
    // engine states
    typedef enum logic [1:0] {FCS_IDLE, FCS_WAIT, FCS_RUN} fcs_state_t;
endpackage

// ### rtl/fcs_scanner.sv
// Purpose: memory integrity scanner with 16-bit checksum and fault request
// Assumes: memory read data valid in the cycle a fetch is taken
// Notes:   APB slave, zero wait states, read data registered in setup
//
// Behaviour
// - failure clears pass flag, vector 0x00
// - arm bit set-only, system reset clears
// - fault request sticky until system reset
// - fault request ignores global interrupt enable
// - sleep freezes scan, resumes on wake
// - pending priority check runs first after wake
// - control writes ignored after fault
// - soft reset clears enable, mode/region, pass flag next cycle
// - soft reset gated by arm and busy
// - arm set only while not busy
// - enable write of one starts check
// - enable zero stops after current pass
// - startup scan leaves enable, background, region
// - mode/region locked while busy or fault
// - mode field decodes priority, single, repeating
// - repeating halts on fail or stop
// - region field decodes three memory areas
// - status register is read-only
// - pass flag reset one, zero while busy
// - busy flag shows scan in progress
// - checksum ccitt, msb first, byte 0 first
// - accumulator preset to all ones
// - priority fetch every third cycle, start 3
`timescale 1ns/1ps
module fcs_scanner #(
    parameter int              AW         = 12,        // word address width
    parameter logic [AW-1:0]   FLASH_LAST = '1         // last word of memory
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_i,
    input  wire logic [3:0]       paddr_i,
    input  wire logic             psel_i,
    input  wire logic             penable_i,
    input  wire logic             pwrite_i,
    input  wire logic [31:0]      pwdata_i,
    output logic      [31:0]      prdata_o,
    output logic                  pready_o,
    output logic                  pslverr_o,
    output logic                  mem_req_o,
    output logic      [AW-1:0]    mem_addr_o,
    input  wire logic             mem_grant_i,
    input  wire logic [15:0]      mem_rdata_i,
    output logic                  cpu_stall_o,
    input  wire logic             cpu_sleep_i,
    input  wire logic [AW-1:0]    loader_last_i,
    input  wire logic [AW-1:0]    program_last_i,
    input  wire logic             init_scan_i,
    input  wire logic [1:0]       init_region_i,
    output logic                  fault_nmi_o,
    output logic      [7:0]       nmi_vec_o,
    output fcs_pkg::fcs_stat_t    stat_o
);
    import fcs_pkg::*;

    // refuse address widths the counters cannot serve
    if (AW < 2 || AW > 24) begin : g_chk
        $error("fcs_scanner: AW out of range");
    end

    // one byte through the checksum, msb first
    function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                             input logic [7:0]  b);
        logic [15:0] r;
        logic        fb;
        r = c;
        for (int i = 7; i >= 0; i--)
        begin
            fb = r[15] ^ b[i];
            r  = {r[14:0], 1'b0};
            if (fb)
                r = r ^ FCS_CRC_POLY;
        end
        return r;
    endfunction

    fcs_state_t  state;          // engine state
    fcs_cfg_t    cfg;            // mode and region
    logic        enable;         // enable bit as read back
    logic        arm;            // fault_irq_arm
    logic        nmi;            // latched fault request
    logic        ok;             // raw pass flag
    logic        stop_req;       // finish pass, then stop
    logic        pend_wake;      // priority check waiting on wake
    logic        init_done;      // startup strap already taken
    logic        srst_q;         // soft reset, one cycle late
    logic [1:0]  cnt;            // start delay countdown
    logic [1:0]  phase;          // priority fetch spacing
    logic [AW-1:0] addr;         // current word address
    logic [15:0] crc;            // checksum accumulator
    logic [15:0] crc_nxt;        // accumulator after this word
    logic [AW-1:0] last_addr;    // last word of selected region
    logic        busy;           // scan in progress
    logic        prio;           // priority mode selected
    logic        step;           // a word is taken this cycle
    logic        last_step;      // final word of region taken
    logic        fail_now;       // region finished with a mismatch
    logic        wr;             // apb write access phase
    logic [1:0]  idx;            // register index
    logic        wr_ctrl;        // accepted control write
    logic        srst_ok;        // soft reset strobe accepted
    logic        go_wr;          // launch from software
    logic        init_go;        // launch from startup strap

    // bus decode
    assign idx      = paddr_i[3:2];
    assign wr       = psel_i & penable_i & pwrite_i;
    assign wr_ctrl  = wr & (idx == FCS_IDX_CTRL) & ~nmi;
    assign srst_ok  = pwdata_i[FCS_B_SRST] & (~arm | ~busy);
    assign go_wr    = wr_ctrl & pwdata_i[FCS_B_EN];
    assign init_go  = ~init_done & init_scan_i;

    // engine helpers
    assign busy     = (state != FCS_IDLE);
    assign prio     = (cfg.mode == FCS_MODE_PRIO);
    assign crc_nxt  = crc_byte(crc_byte(crc, mem_rdata_i[7:0]),
                               mem_rdata_i[15:8]);
    // priority walks on its own spacing, background waits for grant
    assign step     = (state == FCS_RUN) & ~cpu_sleep_i &
                      (prio ? (phase == 2'h0) : mem_grant_i);
    assign last_step = step & (addr == last_addr);
    assign fail_now  = last_step & (crc_nxt != 16'h0000);

    // region end select
    always_comb
    begin
        if (cfg.region == FCS_REG_LDR)
            last_addr = loader_last_i;
        else if (cfg.region == FCS_REG_LDPG)
            last_addr = program_last_i;
        else
            last_addr = FLASH_LAST; // full and reserved
    end

    // startup strap, caught once after reset release
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            init_done <= 1'b0;
        else
            init_done <= 1'b1;
    end

    // soft reset strobe delay; strobe itself holds nothing
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            srst_q <= 1'b0;
        else
            srst_q <= wr_ctrl & srst_ok;
    end

    // arm bit and fault latch, system reset only
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            arm <= FCS_CTRL_RST[FCS_B_ARM];
            nmi <= 1'b0;
        end
        else
        begin
            // set only, and only when idle
            if (wr_ctrl & pwdata_i[FCS_B_ARM] & ~busy)
                arm <= 1'b1;
            // sticky, no global enable gate
            if (fail_now & arm)
                nmi <= 1'b1;
        end
    end

    // mode and region register
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            cfg <= fcs_cfg_t'({FCS_MR_RST[FCS_MODE_LO +: 2],
                               FCS_MR_RST[FCS_REG_LO +: 2]});
        else if (srst_q)
            cfg <= fcs_cfg_t'(4'h0);
        else if (init_go)
        begin
            cfg.mode   <= FCS_MODE_BG;
            cfg.region <= init_region_i;
        end
        else if (wr & (idx == FCS_IDX_MR) & ~busy & ~nmi)
        begin
            cfg.mode   <= pwdata_i[FCS_MODE_LO +: 2];
            cfg.region <= pwdata_i[FCS_REG_LO +: 2];
        end
    end

    // scan engine
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state     <= FCS_IDLE;
            enable    <= FCS_CTRL_RST[FCS_B_EN];
            ok        <= FCS_STAT_RST[FCS_B_OK];
            stop_req  <= 1'b0;
            pend_wake <= 1'b0;
            cnt       <= 2'h0;
            phase     <= 2'h0;
            addr      <= '0;
            crc       <= FCS_CRC_INIT;
        end
        else if (srst_q)
        begin
            // engine, enable and pass flag cleared; arm and fault latch keep their values
            state     <= FCS_IDLE;
            enable    <= 1'b0;
            ok        <= 1'b0;
            stop_req  <= 1'b0;
            pend_wake <= 1'b0;
        end
        else if (init_go | go_wr)
        begin
            // fresh check with current settings
            state     <= FCS_WAIT;
            enable    <= 1'b1;
            ok        <= 1'b0;
            stop_req  <= 1'b0;
            pend_wake <= 1'b0;
            cnt       <= FCS_START_CYC;
            phase     <= 2'h0;
            addr      <= '0;
            crc       <= FCS_CRC_INIT;
        end
        else
        begin
            // disable waits for the end of this pass
            if (wr_ctrl & ~pwdata_i[FCS_B_EN])
            begin
                enable   <= 1'b0;
                stop_req <= busy;
            end
            // remember a priority check not yet begun at sleep
            if (cpu_sleep_i & (state == FCS_WAIT) & prio)
                pend_wake <= 1'b1;
            if (!cpu_sleep_i)
            begin
                case (state)
                    FCS_WAIT:
                    begin
                        cnt <= cnt - 2'h1;
                        if (cnt == 2'h1)
                            state <= FCS_RUN;
                    end
                    FCS_RUN:
                    begin
                        // spacing counter for priority fetches
                        if (phase == FCS_FETCH_CYC - 2'h1)
                            phase <= 2'h0;
                        else
                            phase <= phase + 2'h1;
                        if (step)
                        begin
                            crc  <= crc_nxt;
                            addr <= addr + 1'b1;
                        end
                        if (last_step)
                        begin
                            ok <= ~fail_now;
                            if ((cfg.mode == FCS_MODE_CONT) & ~fail_now &
                                enable & ~stop_req)
                            begin
                                // repeat from region start
                                addr  <= '0;
                                crc   <= FCS_CRC_INIT;
                                phase <= 2'h0;
                            end
                            else
                            begin
                                state     <= FCS_IDLE;
                                stop_req  <= 1'b0;
                                pend_wake <= 1'b0;
                            end
                        end
                    end
                    default:
                    begin
                        cnt <= 2'h0;
                    end
                endcase
            end
        end
    end

    // apb read data, registered in the setup cycle
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            prdata_o <= 32'h0000_0000;
        else if (psel_i & ~penable_i & ~pwrite_i)
        begin
            prdata_o <= 32'h0000_0000;
            if (idx == FCS_IDX_CTRL)
            begin
                prdata_o[FCS_B_EN]  <= enable;
                prdata_o[FCS_B_ARM] <= arm;
            end
            else if (idx == FCS_IDX_MR)
            begin
                prdata_o[FCS_MODE_LO +: 2] <= cfg.mode;
                prdata_o[FCS_REG_LO +: 2]  <= cfg.region;
            end
            else if (idx == FCS_IDX_STAT)
            begin
                // status has no write path at all
                prdata_o[FCS_B_BUSY] <= busy;
                prdata_o[FCS_B_OK]   <= ok & ~busy;
            end
        end
    end

    // zero wait states, unmapped reads return zero
    assign pready_o    = 1'b1;
    assign pslverr_o   = 1'b0;
    // memory side and cpu stall
    assign mem_req_o   = (state == FCS_RUN) & ~cpu_sleep_i & ~prio;
    assign mem_addr_o  = addr;
    assign cpu_stall_o = ~cpu_sleep_i & prio &
                         ((state == FCS_RUN) | pend_wake);
    assign fault_nmi_o = nmi;
    assign nmi_vec_o   = FCS_NMI_VEC;
    assign stat_o      = '{ok: ok & ~busy, busy: busy};

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    // three quiet wait cycles lead into the fetch phase
    sequence s_wait3;
        (state == FCS_WAIT && !cpu_sleep_i && !srst_q && !go_wr)[*3];
    endsequence
    sequence s_pfetch;
        step && prio && !srst_q && !go_wr;
    endsequence

    chk_nmi_sticky: assert property (fault_nmi_o |=> fault_nmi_o)
        else $error("fault request withdrawn");
    chk_nmi_cause: assert property ($rose(fault_nmi_o)
        |-> $past(fail_now) && $past(arm))
        else $error("fault request without failure");
    chk_arm_sticky: assert property (arm |=> arm)
        else $error("arm bit cleared");
    chk_arm_idle: assert property ($rose(arm) |-> $past(!busy))
        else $error("arm set while busy");
    chk_start_delay: assert property (s_wait3 |=> state == FCS_RUN)
        else $error("start delay wrong");
    chk_prio_rate: assert property (s_pfetch
        |=> (!step || srst_q || go_wr)[*2])
        else $error("priority fetch too fast");
    chk_srst_clear: assert property (srst_q && !nmi
        |=> !enable && state == FCS_IDLE && cfg == 4'h0)
        else $error("soft reset did not clear");
    chk_cfg_lock: assert property ((busy || nmi) && !srst_q
        |=> $stable(cfg))
        else $error("mode/region changed while locked");
    chk_ctrl_lock: assert property (nmi && wr && idx == FCS_IDX_CTRL
        |=> $stable(enable) && $stable(arm))
        else $error("control write after fault");
    chk_sleep_hold: assert property (cpu_sleep_i && !srst_q && !go_wr
        |=> $stable(addr) && $stable(crc))
        else $error("scan moved during sleep");
    chk_bg_grant: assert property (state == FCS_RUN && !prio &&
        !mem_grant_i && !srst_q && !go_wr |=> $stable(addr))
        else $error("background advanced without grant");
    chk_ok_busy: assert property (go_wr && !srst_q
        |=> busy && !stat_o.ok)
        else $error("pass flag not cleared on start");
endmodule

// ### verification/fcs_flash_model.sv
// Purpose: program memory and cpu fetch port model beside the scanner
// Assumes: background cycles are granted only while the scanner asks
// Notes:   data outside a cycle the scanner may take is inverted
`timescale 1ns/1ps
module fcs_flash_model #(
    parameter int AW = 6                // word address width
) (
    input  wire logic          core_clk_i,
    input  wire logic          mem_req_i,
    input  wire logic [AW-1:0] mem_addr_i,
    input  wire logic          cpu_stall_i,
    input  wire logic          slow_i,
    output logic               mem_grant_o,
    output logic      [15:0]   mem_rdata_o
);
    logic [15:0] mem [0:(1<<AW)-1];     // word store, filled by the bench
    logic [1:0]  slot = 2'h0;           // free cycle counter of a busy cpu
    // busy cpu leaves one free cycle in four
    always_ff @(posedge core_clk_i)
    begin
        slot <= slot + 2'h1;
    end
    // cpu keeps priority in background modes
    assign mem_grant_o = mem_req_i && (!slow_i || slot == 2'h0);
    // stale reads would show wrong data, never a lucky match
    assign mem_rdata_o = (mem_grant_o || cpu_stall_i) ? mem[mem_addr_i]
                                                      : ~mem[mem_addr_i];
endmodule

// ### verification/fcs_tb.sv
// Purpose: self-checking bench for the memory integrity scanner
// Assumes: zero wait apb slave, regions end at words 7, 15 and 63
// Notes:   memory checksums are built here before the run
`timescale 1ns/1ps
module tb;
    import fcs_pkg::*;
    localparam int         AW     = 6;
    localparam logic [3:0] A_CTRL = {FCS_IDX_CTRL, 2'b00};
    localparam logic [3:0] A_MR   = {FCS_IDX_MR, 2'b00};
    localparam logic [3:0] A_ST   = {FCS_IDX_STAT, 2'b00};
    logic core_clk_i, rst_i, psel_i, penable_i, pwrite_i;
    logic [3:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic pready_o, mem_req_o, mem_grant, cpu_stall_o, cpu_sleep_i;
    logic pslverr_o;
    logic [AW-1:0] mem_addr_o;
    logic [15:0] mem_rdata;
    logic init_scan_i, fault_nmi_o, slow, stall_seen;
    logic [1:0] init_region_i;
    logic [7:0] nmi_vec_o;
    fcs_stat_t stat_o;
    int err_count = 0;
    int checks = 0;
    int ends [3] = '{7, 15, 63};
    fcs_scanner #(.AW(AW), .FLASH_LAST(6'h3f)) i_fcs_scanner (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .paddr_i(paddr_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .mem_req_o(mem_req_o),
        .mem_addr_o(mem_addr_o),
        .mem_grant_i(mem_grant), .mem_rdata_i(mem_rdata),
        .cpu_stall_o(cpu_stall_o), .cpu_sleep_i(cpu_sleep_i),
        .loader_last_i(6'h07), .program_last_i(6'h0f),
        .init_scan_i(init_scan_i), .init_region_i(init_region_i),
        .fault_nmi_o(fault_nmi_o), .nmi_vec_o(nmi_vec_o), .stat_o(stat_o));
    fcs_flash_model #(.AW(AW)) i_fcs_flash_model (
        .core_clk_i(core_clk_i), .mem_req_i(mem_req_o),
        .mem_addr_i(mem_addr_o), .cpu_stall_i(cpu_stall_o),
        .slow_i(slow), .mem_grant_o(mem_grant), .mem_rdata_o(mem_rdata));
    // 25 mhz clock
    initial
    begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] crc8(input logic [15:0] c,
                                         input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? FCS_CRC_POLY : 16'h0);
        return c;
    endfunction
    // checksum stored high byte first at each region end
    task automatic fill();
        logic [15:0] c;
        for (int i = 0; i < 64; i++)
            i_fcs_flash_model.mem[i] = {8'(i) ^ 8'h5a, 8'(i)};
        foreach (ends[k])
        begin
            c = FCS_CRC_INIT;
            for (int j = 0; j < ends[k]; j++)
            begin
                c = crc8(c, i_fcs_flash_model.mem[j][7:0]);
                c = crc8(c, i_fcs_flash_model.mem[j][15:8]);
            end
            i_fcs_flash_model.mem[ends[k]] = {c[7:0], c[15:8]};
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [3:0] a,
                       input logic [7:0] d, output logic [31:0] q);
        int n;
        @(posedge core_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= {24'h0, d};
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            err_count++;
            results();
        end
        q = prdata_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        logic [31:0] q;
        apb(1'b0, a, 8'h0, q);
        chk(q, {24'h0, e});
    endtask
    // bounded wait for busy to fall, noting any cpu stall
    task automatic wait_idle();
        int n;
        n = 0;
        while (stat_o.busy !== 1'b0 && n < 2000)
        begin
            @(posedge core_clk_i);
            stall_seen = stall_seen | cpu_stall_o;
            n++;
        end
        if (n >= 2000)
        begin
            err_count++;
            results();
        end
    endtask
    task automatic gap(output int n);
        logic [AW-1:0] a;
        a = mem_addr_o;
        n = 0;
        while (mem_addr_o === a && n < 20)
        begin
            @(posedge core_clk_i);
            n++;
        end
        // a stalled address counts as a mismatch
        if (n >= 20)
        begin
            err_count++;
            results();
        end
    endtask
    task automatic do_reset(input logic init, input logic [1:0] r);
        rst_i <= 1'b1;
        init_scan_i <= init;
        init_region_i <= r;
        tick(3);
        rst_i <= 1'b0;
    endtask
    task automatic t_regs();
        rd_chk(A_CTRL, FCS_CTRL_RST);
        rd_chk(A_MR, FCS_MR_RST);
        rd_chk(A_ST, FCS_STAT_RST);
        wr(A_ST, 8'h01);
        wr(4'hc, 8'hff);
        chk(pslverr_o, 1'b0);
        rd_chk(A_ST, FCS_STAT_RST);
        rd_chk(A_CTRL, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_init();
        do_reset(1'b1, FCS_REG_LDR);
        rd_chk(A_CTRL, 8'h01);
        rd_chk(A_MR, {2'b00, FCS_MODE_BG, 2'b00, FCS_REG_LDR});
        init_scan_i <= 1'b0;
        wait_idle();
        rd_chk(A_ST, 8'h02);
        $display("test init done");
    endtask
    task automatic t_prio();
        int n;
        wr(A_MR, {2'b00, FCS_MODE_PRIO, 2'b00, FCS_REG_LDR});
        wr(A_CTRL, 8'h01);
        rd_chk(A_ST, 8'h01);
        gap(n);
        gap(n);
        chk(n, 3);
        chk(cpu_stall_o, 1'b1);
        chk(mem_req_o, 1'b0);
        wait_idle();
        rd_chk(A_ST, 8'h02);
        rd_chk(A_CTRL, 8'h01);
        wr(A_CTRL, 8'h01);
        tick(2);
        chk(stat_o.busy, 1'b1);
        wait_idle();
        $display("test priority done");
    endtask
    task automatic t_bg();
        slow <= 1'b1;
        for (int r = 0; r < 3; r++)
        begin
            wr(A_MR, {2'b00, FCS_MODE_BG, 2'b00, 2'(r)});
            wr(A_CTRL, 8'h01);
            stall_seen = 1'b0;
            tick(2);
            wait_idle();
            chk(stall_seen, 1'b0);
            rd_chk(A_ST, 8'h02);
        end
        $display("test background done");
    endtask
    task automatic t_cont();
        slow <= 1'b0;
        wr(A_MR, {2'b00, FCS_MODE_CONT, 2'b00, FCS_REG_LDR});
        wr(A_CTRL, 8'h01);
        tick(40);
        chk(stat_o.busy, 1'b1);
        chk(mem_req_o, 1'b1);
        wr(A_MR, 8'h00);
        rd_chk(A_MR, 8'h32);
        wr(A_CTRL, 8'h00);
        wait_idle();
        rd_chk(A_ST, 8'h02);
        $display("test continuous done");
    endtask
    task automatic t_sleep();
        logic [AW-1:0] a;
        wr(A_MR, {2'b00, FCS_MODE_PRIO, 2'b00, FCS_REG_LDPG});
        wr(A_CTRL, 8'h01);
        cpu_sleep_i <= 1'b1;
        tick(10);
        cpu_sleep_i <= 1'b0;
        tick(1);
        chk(cpu_stall_o, 1'b1);
        tick(12);
        cpu_sleep_i <= 1'b1;
        tick(1);
        a = mem_addr_o;
        tick(10);
        chk(mem_addr_o, a);
        chk(stat_o.busy, 1'b1);
        cpu_sleep_i <= 1'b0;
        wait_idle();
        rd_chk(A_ST, 8'h02);
        $display("test sleep done");
    endtask
    task automatic t_srst();
        slow <= 1'b1;
        wr(A_MR, {2'b00, FCS_MODE_BG, 2'b00, FCS_REG_FULL});
        wr(A_CTRL, 8'h01);
        wr(A_CTRL, 8'h03);
        rd_chk(A_CTRL, 8'h01);
        wr(A_CTRL, 8'h80);
        tick(2);
        chk(stat_o, 2'b00);
        rd_chk(A_CTRL, 8'h00);
        rd_chk(A_MR, 8'h00);
        $display("test soft reset done");
    endtask
    task automatic t_fault();
        i_fcs_flash_model.mem[3] = i_fcs_flash_model.mem[3] ^ 16'h0001;
        wr(A_CTRL, 8'h02);
        rd_chk(A_CTRL, 8'h02);
        wr(A_MR, {2'b00, FCS_MODE_BG, 2'b00, FCS_REG_LDR});
        wr(A_CTRL, 8'h03);
        wr(A_CTRL, 8'h82);
        rd_chk(A_MR, 8'h22);
        wait_idle();
        chk(fault_nmi_o, 1'b1);
        chk(nmi_vec_o, FCS_NMI_VEC);
        rd_chk(A_ST, 8'h00);
        wr(A_CTRL, 8'h80);
        wr(A_MR, 8'h00);
        rd_chk(A_MR, 8'h22);
        rd_chk(A_CTRL, 8'h02);
        chk(fault_nmi_o, 1'b1);
        do_reset(1'b0, 2'h0);
        chk(fault_nmi_o, 1'b0);
        rd_chk(A_CTRL, 8'h00);
        $display("test fault done");
    endtask
    // main sequence
    initial
    begin
        rst_i = 1'b1;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 4'h0;
        pwdata_i = 32'h0;
        cpu_sleep_i = 1'b0;
        init_scan_i = 1'b0;
        init_region_i = 2'h0;
        slow = 1'b0;
        stall_seen = 1'b0;
        fill();
        tick(3);
        rst_i <= 1'b0;
        t_regs();
        t_init();
        t_prio();
        t_bg();
        t_cont();
        t_sleep();
        t_srst();
        t_fault();
        results();
    end
endmodule
